// ==== rtl/ufl_pkg.sv ====
// Shared constants and carrier types for the UART FIFO level and interrupt mask block.
// Assumes a 32-bit register port with byte offsets and a single 50 MHz clock domain.
package ufl_pkg;

    // Register port geometry
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_THRESHOLD = 8'h34;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h38;
    localparam logic [ADDR_W-1:0] ADDR_RAW_STATUS = 8'h3C;
    localparam logic [ADDR_W-1:0] ADDR_MASKED_STATUS = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR = 8'h44;

    // Level select codes, fraction of the FIFO depth
    localparam logic [2:0] LEVEL_1_64 = 3'h0;
    localparam logic [2:0] LEVEL_1_32 = 3'h1;
    localparam logic [2:0] LEVEL_1_16 = 3'h2;
    localparam logic [2:0] LEVEL_1_8 = 3'h3;
    localparam logic [2:0] LEVEL_1_4 = 3'h4;
    localparam logic [2:0] LEVEL_1_2 = 3'h5;
    localparam logic [2:0] LEVEL_3_4 = 3'h6;
    localparam logic [2:0] LEVEL_RESERVED = 3'h7;

    // Values after reset and implemented bit sets
    localparam logic [2:0] LEVEL_SEL_RESET = LEVEL_1_16;
    localparam logic [DATA_W-1:0] THRESHOLD_RESET = 32'h00000012;
    localparam logic [DATA_W-1:0] THRESHOLD_IMPL_BITS = 32'h0000003F;
    localparam logic [DATA_W-1:0] MASK_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] STATUS_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] IRQ_IMPL_BITS = 32'h00001FF2;

    // Default FIFO depth in entries
    localparam int unsigned FIFO_DEPTH_DEFAULT = 64;

    // Threshold register layout
    typedef struct packed {
        logic [25:0] reserved;
        logic [2:0] rxLevelSelect;
        logic [2:0] txLevelSelect;
    } ufl_threshold_type;

    // Common layout of mask, raw status, masked status and clear
    typedef struct packed {
        logic [18:0] reservedHigh;
        logic txEmpty;
        logic flowPause;
        logic overrunErr;
        logic breakErr;
        logic parityErr;
        logic framingErr;
        logic rxTimeout;
        logic transmit;
        logic receive;
        logic [1:0] reservedMid;
        logic ctsChange;
        logic reservedLow;
    } ufl_irq_bits_type;

    // One register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic wrEn;
        logic rdEn;
    } ufl_bus_req_type;

    // Event lines from the rest of the UART, high while the condition stands
    typedef struct packed {
        logic ctsChange;
        logic rxTimeout;
        logic framingErr;
        logic parityErr;
        logic breakErr;
        logic overrunErr;
        logic flowPause;
        logic txEmpty;
    } ufl_line_event_type;

endpackage

// ==== rtl/ufl_level_cmp.sv ====
// FIFO trigger level comparator: compares an entry count with the selected fraction of depth.
// Assumes the count is already free entries (transmit) or filled entries (receive).
`timescale 1ns/1ps
`default_nettype none
module ufl_level_cmp
    import ufl_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH_DEFAULT, // FIFO entries
    parameter int unsigned CNT_W = $clog2(DEPTH) + 1 // Count width
) (
    input wire logic [CNT_W-1:0] amount, // Entries free or filled
    input wire logic [2:0] levelSelect, // Trigger code
    output logic reached // Amount at or above trigger point
);

    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

    // Fraction of depth per code; reserved code behaves as three quarters
    function automatic logic [CNT_W-1:0] level_threshold(input logic [2:0] sel);
        logic [CNT_W-1:0] t;
        t = DEPTH_C;
        unique case (sel)
            LEVEL_1_64: t = DEPTH_C >> 6;
            LEVEL_1_32: t = DEPTH_C >> 5;
            LEVEL_1_16: t = DEPTH_C >> 4;
            LEVEL_1_8: t = DEPTH_C >> 3;
            LEVEL_1_4: t = DEPTH_C >> 2;
            LEVEL_1_2: t = DEPTH_C >> 1;
            LEVEL_3_4, LEVEL_RESERVED: t = (DEPTH_C >> 1) + (DEPTH_C >> 2); // RQ12
        endcase
        // Shallow FIFOs would round small fractions to zero and fire forever
        if (t == '0) begin
            t = ONE_C;
        end
        return t;
    endfunction

    wire [CNT_W-1:0] triggerPoint = level_threshold(levelSelect);
    assign reached = (amount >= triggerPoint);

endmodule // ufl_level_cmp
`default_nettype wire

// ==== rtl/ufl_irq_ctrl.sv ====
// UART FIFO trigger level register, interrupt mask, sticky status and interrupt output.
// Assumes FIFO counts and event lines are synchronous to ref_clk; strobes are one cycle.
//
// Overview of operation
// RQ1: Bits 2:0 pick the transmit trigger, 1/64 up to 3/4 of FIFO empty.
// RQ2: Transmit trigger code resets to 2, one sixteenth empty.
// RQ3: Bits 5:3 pick the receive trigger, 1/64 up to 3/4 of FIFO full.
// RQ4: Receive trigger code resets to 2, one sixteenth full.
// RQ5: Mask bit one enables, zero disables; reads return it; all reset to zero.
// RQ6: Mask bit 1 gates the clear-to-send change interrupt.
// RQ7: Mask bits 4, 5, 6 gate receive, transmit and receive timeout.
// RQ8: Mask bits 7 to 10 gate framing, parity, break and overrun errors.
// RQ9: Mask bit 11 gates the flow pause received interrupt.
// RQ10: Mask bit 12 gates the transmit FIFO empty interrupt.
// RQ11: Interrupt outputs and masked status equal raw status ANDed with mask.
// RQ12: Trigger code 7 is reserved and acts like the three quarter setting.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ufl_irq_ctrl
    import ufl_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEFAULT, // Entries in each FIFO
    parameter int unsigned CNT_W = $clog2(FIFO_DEPTH) + 1 // FIFO count width
) (
    input wire logic ref_clk, // 50 MHz clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire ufl_bus_req_type busReq, // Register port request
    output logic [DATA_W-1:0] rdData, // Read data, cycle after the strobe
    input wire logic [CNT_W-1:0] rxCount, // Receive FIFO filled entries
    input wire logic [CNT_W-1:0] txCount, // Transmit FIFO filled entries
    input wire ufl_line_event_type lineEvent, // Event lines from the UART
    output var ufl_irq_bits_type irqLines, // Per-source masked interrupts
    output logic irq, // Combined interrupt, level
    output logic [2:0] txLevelSelect, // Current transmit trigger code
    output logic [2:0] rxLevelSelect // Current receive trigger code
);

    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(FIFO_DEPTH);

    // Address match, shared by the write and read decoders
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] offset);
        return addr == offset;
    endfunction

    ufl_threshold_type threshold;
    ufl_irq_bits_type mask;
    ufl_irq_bits_type rawStatus;

    ufl_threshold_type next_threshold;
    ufl_irq_bits_type next_mask;
    ufl_irq_bits_type next_rawStatus;
    ufl_irq_bits_type next_masked;
    logic [DATA_W-1:0] next_rdData;

    // Write decode
    wire wrThreshold = busReq.wrEn && addr_hit(busReq.addr, ADDR_THRESHOLD);
    wire wrMask = busReq.wrEn && addr_hit(busReq.addr, ADDR_MASK);
    wire wrClear = busReq.wrEn && addr_hit(busReq.addr, ADDR_CLEAR);

    // Read decode
    wire rdThreshold = addr_hit(busReq.addr, ADDR_THRESHOLD);
    wire rdMask = addr_hit(busReq.addr, ADDR_MASK);
    wire rdRaw = addr_hit(busReq.addr, ADDR_RAW_STATUS);
    wire rdMasked = addr_hit(busReq.addr, ADDR_MASKED_STATUS);

    // Reserved bits are dropped on write so they always read back as zero
    wire [DATA_W-1:0] thresholdWrite = busReq.wrData & THRESHOLD_IMPL_BITS; // RQ1 RQ3
    wire [DATA_W-1:0] irqWrite = busReq.wrData & IRQ_IMPL_BITS;

    assign next_threshold = wrThreshold ? ufl_threshold_type'(thresholdWrite) : threshold;
    assign next_mask = wrMask ? ufl_irq_bits_type'(irqWrite) : mask; // RQ5

    // Free entries in the transmit FIFO; count never exceeds depth
    wire [CNT_W-1:0] txFree = DEPTH_C - txCount;

    wire txLevelReached;
    wire rxLevelReached;

    // Transmit trigger: enough free room to refill
    ufl_level_cmp #(
        .DEPTH(FIFO_DEPTH),
        .CNT_W(CNT_W)
    ) u_tx_level (
        .amount(txFree),
        .levelSelect(threshold.txLevelSelect),
        .reached(txLevelReached)
    ); // RQ1

    // Receive trigger: enough data waiting to drain
    ufl_level_cmp #(
        .DEPTH(FIFO_DEPTH),
        .CNT_W(CNT_W)
    ) u_rx_level (
        .amount(rxCount),
        .levelSelect(threshold.rxLevelSelect),
        .reached(rxLevelReached)
    ); // RQ3

    // Events placed at their status positions
    ufl_irq_bits_type setBits;
    assign setBits.reservedHigh = '0;
    assign setBits.txEmpty = lineEvent.txEmpty; // RQ10
    assign setBits.flowPause = lineEvent.flowPause; // RQ9
    assign setBits.overrunErr = lineEvent.overrunErr; // RQ8
    assign setBits.breakErr = lineEvent.breakErr; // RQ8
    assign setBits.parityErr = lineEvent.parityErr; // RQ8
    assign setBits.framingErr = lineEvent.framingErr; // RQ8
    assign setBits.rxTimeout = lineEvent.rxTimeout; // RQ7
    assign setBits.transmit = txLevelReached; // RQ7
    assign setBits.receive = rxLevelReached; // RQ7
    assign setBits.reservedMid = '0;
    assign setBits.ctsChange = lineEvent.ctsChange; // RQ6
    assign setBits.reservedLow = 1'b0;

    // Write-one-to-clear; a set in the same cycle wins so no event is lost
    wire [DATA_W-1:0] clearBits = wrClear ? irqWrite : '0;
    assign next_rawStatus = ufl_irq_bits_type'((rawStatus & ~clearBits) | setBits);

    // Masked view computed from next values so outputs line up with status
    assign next_masked = next_rawStatus & next_mask; // RQ11

    // Read mux; unmapped offsets and the clear register read as zero
    assign next_rdData = !busReq.rdEn ? '0 :
                         rdThreshold ? threshold :
                         rdMask ? mask : // RQ5
                         rdRaw ? rawStatus :
                         rdMasked ? irqLines : // RQ11
                         '0;

    // Trigger levels
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            threshold <= THRESHOLD_RESET; // RQ2 RQ4
        end else begin
            threshold <= next_threshold;
        end
    end

    // Interrupt enable mask
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= MASK_RESET; // RQ5
        end else begin
            mask <= next_mask;
        end
    end

    // Sticky raw status
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rawStatus <= STATUS_RESET;
        end else begin
            rawStatus <= next_rawStatus;
        end
    end

    // Interrupt outputs held in flops to keep them glitch free
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqLines <= STATUS_RESET;
            irq <= 1'b0;
        end else begin
            irqLines <= next_masked; // RQ6 RQ7 RQ8 RQ9 RQ10 RQ11
            irq <= |next_masked; // RQ11
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
        end else begin
            rdData <= next_rdData;
        end
    end

    // Trigger codes exported straight from the register flops
    assign txLevelSelect = threshold.txLevelSelect;
    assign rxLevelSelect = threshold.rxLevelSelect;

endmodule // ufl_irq_ctrl
`default_nettype wire

// ==== verification/ufl_irq_chk.sv ====
// Port checker for ufl_irq_ctrl: trigger codes, read timing and interrupt masking.
// Assumes the single ref_clk domain; bound into ufl_irq_ctrl by the bind below.
`timescale 1ns/1ps
`default_nettype none
module ufl_irq_chk
    import ufl_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire ufl_bus_req_type busReq, // Register request
    input wire logic [DATA_W-1:0] rdData, // Read data
    input wire ufl_irq_bits_type irqLines, // Masked lines
    input wire logic irq, // Combined interrupt
    input wire logic [2:0] txLevelSelect, // Transmit code
    input wire logic [2:0] rxLevelSelect // Receive code
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Decoded strobes of interest
    wire thrWr = busReq.wrEn && busReq.addr == ADDR_THRESHOLD;
    wire thrRd = busReq.rdEn && busReq.addr == ADDR_THRESHOLD;
    wire maskWr = busReq.wrEn && busReq.addr == ADDR_MASK;
    wire maskRd = busReq.rdEn && busReq.addr == ADDR_MASK;
    wire maskedRd = busReq.rdEn && busReq.addr == ADDR_MASKED_STATUS;

    a_tx_sel_write: assert property (thrWr
        |=> txLevelSelect == $past(busReq.wrData[2:0])) else $error("tx code not taken");
    a_rx_sel_write: assert property (thrWr
        |=> rxLevelSelect == $past(busReq.wrData[5:3])) else $error("rx code not taken");
    a_sel_hold: assert property (!thrWr
        |=> $stable(txLevelSelect) && $stable(rxLevelSelect)) else $error("code moved");
    a_reset_codes: assert property ($rose(rst_n)
        |-> txLevelSelect == LEVEL_SEL_RESET && rxLevelSelect == LEVEL_SEL_RESET)
        else $error("codes not reset to two");
    a_thr_readback: assert property (thrRd
        |=> rdData == {26'h0, rxLevelSelect, txLevelSelect}) else $error("bad threshold read");
    a_rd_idle: assert property (!busReq.rdEn |=> rdData == '0)
        else $error("read data outside its cycle");
    a_mask_gate: assert property (maskWr
        |=> (irqLines & ~$past(busReq.wrData)) == '0) else $error("disabled source seen");
    a_irq_any: assert property (irq == (irqLines != '0))
        else $error("irq disagrees with lines");
    a_impl_bits: assert property ((irqLines & ~IRQ_IMPL_BITS) == '0)
        else $error("reserved line high");
    // Software view of masked status must match the lines it drives
    a_masked_read: assert property (maskedRd
        |=> rdData == $past(irqLines)) else $error("masked status read differs from lines");
    a_mask_impl: assert property (maskRd
        |=> (rdData & ~IRQ_IMPL_BITS) == '0) else $error("reserved mask bit read high");
endmodule // ufl_irq_chk

bind ufl_irq_ctrl ufl_irq_chk chk (.ref_clk, .rst_n, .busReq, .rdData, .irqLines, .irq,
    .txLevelSelect, .rxLevelSelect);
`default_nettype wire

// ==== verification/tb_ufl_irq_ctrl.sv ====
// Testbench for ufl_irq_ctrl: register port tasks, trigger levels and mask scenarios.
// Assumes FIFO depth 64 and the register offsets of ufl_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_ufl_irq_ctrl
    import ufl_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    ufl_bus_req_type busReq = '0;
    logic [6:0] rxCount = 7'h00;
    logic [6:0] txCount = 7'h40;
    ufl_line_event_type lineEvent = '0;
    logic [DATA_W-1:0] rdData;
    ufl_irq_bits_type irqLines;
    logic irq;
    logic [2:0] txLevelSelect;
    logic [2:0] rxLevelSelect;
    int mismatches = 0;
    int totalChecks = 0;
    int cycles = 0;
    int pos;
    int unsigned trig [8] = '{1, 2, 4, 8, 16, 32, 48, 48}; // Code 7 acts as 3/4

    ufl_irq_ctrl dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
        .rxCount(rxCount), .txCount(txCount), .lineEvent(lineEvent),
        .irqLines(irqLines), .irq(irq), .txLevelSelect(txLevelSelect),
        .rxLevelSelect(rxLevelSelect)
    );

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        busReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
        @(posedge ref_clk);
        busReq.wrEn <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge ref_clk);
        busReq <= '{addr: a, wrData: '0, wrEn: 1'b0, rdEn: 1'b1};
        @(posedge ref_clk);
        busReq.rdEn <= 1'b0;
        #1 check(rdData, exp);
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Cycle budget cuts a hung scenario short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            endOfTest();
        end
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(ADDR_THRESHOLD, 32'h12);
        rd(ADDR_MASK, 32'h0);
        wr(ADDR_THRESHOLD, 32'hFFFFFFFF);
        rd(ADDR_THRESHOLD, 32'h3F);
        wr(ADDR_MASK, 32'hFFFFFFFF);
        rd(ADDR_MASK, IRQ_IMPL_BITS);
        wr(8'h80, 32'hFFFFFFFF);
        rd(8'h80, 32'h0);
        wr(ADDR_MASK, 32'h30);
        // Each code: one entry short of its trigger point, then exactly at it
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_THRESHOLD, {26'h0, c[2:0], c[2:0]});
            txCount <= 7'(65 - trig[c]);
            rxCount <= 7'(trig[c] - 1);
            wr(ADDR_CLEAR, IRQ_IMPL_BITS);
            rd(ADDR_RAW_STATUS, 32'h0);
            check({31'h0, irq}, 32'h0);
            check({26'h0, rxLevelSelect, txLevelSelect}, {26'h0, c[2:0], c[2:0]});
            txCount <= 7'(64 - trig[c]);
            rxCount <= 7'(trig[c]);
            rd(ADDR_RAW_STATUS, 32'h30);
            check(irqLines, 32'h30);
        end
        txCount <= 7'h40;
        rxCount <= 7'h00;
        // Every event source: held off by a zero mask, then let through
        for (int k = 0; k < 8; k++) begin
            pos = (k == 7) ? 1 : 12 - k;
            wr(ADDR_CLEAR, IRQ_IMPL_BITS);
            wr(ADDR_MASK, 32'h0);
            lineEvent <= ufl_line_event_type'(8'h01 << k);
            @(posedge ref_clk);
            lineEvent <= '0;
            rd(ADDR_MASKED_STATUS, 32'h0);
            rd(ADDR_RAW_STATUS, 32'h1 << pos);
            wr(ADDR_MASK, 32'h1 << pos);
            #1 check(irqLines, 32'h1 << pos);
            check({31'h0, irq}, 32'h1);
            rd(ADDR_MASKED_STATUS, 32'h1 << pos);
            wr(ADDR_CLEAR, 32'h1 << pos);
            #1 check({31'h0, irq}, 32'h0);
        end
        // Event held through its clear: the set wins and the bit stays
        wr(ADDR_MASK, IRQ_IMPL_BITS);
        lineEvent.parityErr <= 1'b1;
        wr(ADDR_CLEAR, IRQ_IMPL_BITS);
        lineEvent.parityErr <= 1'b0;
        rd(ADDR_RAW_STATUS, 32'h100);
        // Status registers ignore writes, the clear register reads as zero
        wr(ADDR_RAW_STATUS, 32'h0);
        wr(ADDR_MASKED_STATUS, 32'h0);
        rd(ADDR_MASKED_STATUS, 32'h100);
        rd(ADDR_CLEAR, 32'h0);
        // Reset in mid-run: registers and outputs fall back with no clock needed
        wr(ADDR_THRESHOLD, 32'h1B);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        #1 check(irqLines, STATUS_RESET);
        check({31'h0, irq}, 32'h0);
        check({26'h0, rxLevelSelect, txLevelSelect}, THRESHOLD_RESET);
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(ADDR_THRESHOLD, THRESHOLD_RESET);
        rd(ADDR_MASK, MASK_RESET);
        rd(ADDR_RAW_STATUS, STATUS_RESET);
        endOfTest();
    end
endmodule // tb_ufl_irq_ctrl
`default_nettype wire
